// [rtl/level_priority_resolver.sv]
// Picks the winning interrupt level from the gated requests.
// Assumes requests are already masked by the caller; the caller applies global enable after the pick.
`default_nettype none

module level_priority_resolver #(
	parameter logic [47:0] GROUP_ORDER = vic_pkg::GROUP_ORDER_DEF
) (
	// Requests and priority setting
	input  wire logic [7:0] req_in,
	input  wire logic [7:0] prio_in,
	// Winner
	output logic            valid_out,
	output logic [2:0]      level_out
);

	////////////////////////////////////////////////////////////////////////
	function automatic logic [3:0] first_of2(input logic [7:0] r,
		input logic [2:0] x, input logic [2:0] y);
		if (r[x])
			first_of2 = {1'b1, x};
		else
			first_of2 = {r[y], y};
	endfunction

	logic [3:0] grp_a;
	logic [3:0] grp_b;
	logic [3:0] grp_c;
	logic [3:0] sub67;
	logic [3:0] grp [3];
	logic [5:0] order;
	logic [1:0] g;

	always_comb
	begin
		// Within group A the low priority bit picks level 0 or 1
		if (prio_in[vic_pkg::PRIO_A])
			grp_a = first_of2(req_in, 3'd1, 3'd0);
		else
			grp_a = first_of2(req_in, 3'd0, 3'd1);
		grp_b = first_of2(req_in, 3'd2, 3'd3);
		if (!grp_b[3])
			grp_b = {req_in[4], 3'd4};
		// Subgroup of 6 and 7, then level 5 against the subgroup
		if (prio_in[vic_pkg::PRIO_SUB])
			sub67 = first_of2(req_in, 3'd7, 3'd6);
		else
			sub67 = first_of2(req_in, 3'd6, 3'd7);
		if (prio_in[vic_pkg::PRIO_C])
			grp_c = sub67[3] ? sub67 : {req_in[5], 3'd5};
		else
			grp_c = req_in[5] ? {1'b1, 3'd5} : sub67;
		grp[0] = grp_a;
		grp[1] = grp_b;
		grp[2] = grp_c;
		order = GROUP_ORDER[6*{prio_in[vic_pkg::PRIO_G2],
			prio_in[vic_pkg::PRIO_G1],
			prio_in[vic_pkg::PRIO_G0]} +: 6];
		valid_out = 1'b0;
		level_out = 3'd0;
		for (int i = 2; i >= 0; i--)
		begin
			g = order[2*i +: 2];
			if (!valid_out && g != 2'd3 && grp[g][3])
			begin
				valid_out = 1'b1;
				level_out = grp[g][2:0];
			end
		end
	end

endmodule

`default_nettype wire

// [rtl/vectored_interrupt_controller.sv]
// Eight-level vectored interrupt controller with fast interrupt path.
// Assumes the CPU core shares the clock, presents its register-file access
// here, signals instruction boundaries and pops for the return itself.
`default_nettype none

module vectored_interrupt_controller #(
	parameter logic [7:0]  HW_CLEAR    = vic_pkg::HW_CLEAR_LEVELS,
	parameter logic [7:0]  VEC_BASE    = vic_pkg::VECTOR_BASE,
	parameter logic [47:0] GROUP_ORDER = vic_pkg::GROUP_ORDER_DEF
) (
	// Clock and reset
	input  wire logic               ref_clk_in,
	input  wire logic               rst_n_in,
	// Register file access
	input  wire logic [7:0]         reg_addr_in,
	input  wire logic               reg_wr_in,
	input  wire logic [7:0]         reg_wdata_in,
	output logic [7:0]              reg_rdata_out,
	// Instruction events from the core
	input  wire logic               instr_end_in,
	input  wire logic               global_unmask_instr_in,
	input  wire logic               global_mask_instr_in,
	input  wire logic               return_from_service_in,
	input  wire logic [15:0]        ret_pc_in,
	input  wire logic [7:0]         ret_flags_in,
	// Core state
	input  wire logic [15:0]        pc_in,
	input  wire logic [7:0]         flags_in,
	input  wire logic [7:0]         rom_data_in,
	// Interrupt sources: events for hidden levels, enabled levels else
	input  wire logic [7:0]         src_req_in,
	// Toward the core
	output var vic_pkg::cpu_ctl_t   cpu_ctl_out,
	output logic                    acknowledge_strobe_out,
	output logic [2:0]              ack_level_out,
	output logic                    busy_out,
	output logic                    fast_status_out,
	output logic [7:0]              level_pulse_out
);

	////////////////////////////////////////////////////////////////////////
	// Register state
	logic [vic_pkg::SYM_W-1:0] sym_reg, sym_next;
	logic [7:0]  mask_reg, mask_next;
	logic [7:0]  prio_reg, prio_next;
	logic [15:0] fvp_reg, fvp_next;
	logic [7:0]  status_reg, status_next;
	logic [7:0]  pend_reg, pend_next;
	logic [7:0]  rdata_reg, rdata_next;
	logic [7:0]  pulse_reg, pulse_next;

	// Entry machine state
	vic_pkg::entry_state_t st_reg, st_next;
	vic_pkg::cpu_ctl_t     ctl_reg, ctl_next;
	logic [4:0]  cnt_reg, cnt_next;
	logic [4:0]  total_reg, total_next;
	logic [2:0]  lvl_reg, lvl_next;
	logic [15:0] pcs_reg, pcs_next;
	logic [7:0]  flgs_reg, flgs_next;
	logic [7:0]  vhi_reg, vhi_next;
	logic [7:0]  shadow_reg, shadow_next;
	logic        fast_reg, fast_next;
	logic        ack_reg, ack_next;

	logic [7:0]  active;
	logic        win_valid;
	logic [2:0]  win_level;

	////////////////////////////////////////////////////////////////////////
	// Hidden pending bits for hardware-cleared levels, source levels else
	always_comb
	begin
		active = (pend_reg & HW_CLEAR) | (src_req_in & ~HW_CLEAR);
	end

	level_priority_resolver #(
		.GROUP_ORDER(GROUP_ORDER)
	) u_resolver (
		.req_in   (active & mask_reg),
		.prio_in  (prio_reg),
		.valid_out(win_valid),
		.level_out(win_level)
	);

	////////////////////////////////////////////////////////////////////////
	// Register file and pending logic
	always_comb
	begin
		sym_next    = sym_reg;
		mask_next   = mask_reg;
		prio_next   = prio_reg;
		fvp_next    = fvp_reg;
		pend_next   = pend_reg;
		status_next = active;
		pulse_next  = src_req_in & HW_CLEAR & ~pend_reg;
		if (reg_wr_in)
		begin
			case (reg_addr_in)
				vic_pkg::ADDR_FVH:  fvp_next[15:8] = reg_wdata_in;
				vic_pkg::ADDR_FVL:  fvp_next[7:0] = reg_wdata_in;
				vic_pkg::ADDR_MASK: mask_next = reg_wdata_in;
				vic_pkg::ADDR_SYM:  sym_next = reg_wdata_in[4:0];
				vic_pkg::ADDR_PRIO: prio_next = reg_wdata_in;
				default:            ;
			endcase
		end
		// Status register takes no write
		if (global_unmask_instr_in)
			sym_next[vic_pkg::SYM_GIE] = 1'b1;
		if (global_mask_instr_in)
			sym_next[vic_pkg::SYM_GIE] = 1'b0;
		if (st_reg == vic_pkg::ST_IDLE && return_from_service_in)
			sym_next[vic_pkg::SYM_GIE] = 1'b1;
		if (ack_next)
		begin
			sym_next[vic_pkg::SYM_GIE] = 1'b0;
			pend_next[win_level] = 1'b0;
		end
		// Pointer swaps with the PC on fast entry and on fast return
		if (st_next == vic_pkg::ST_FAST)
			fvp_next = pc_in;
		if (st_reg == vic_pkg::ST_IDLE && return_from_service_in && fast_reg)
			fvp_next = ret_pc_in;
		// A new event wins over the clear in the same cycle
		pend_next = pend_next | (src_req_in & HW_CLEAR);
		case (reg_addr_in)
			vic_pkg::ADDR_FVH:  rdata_next = fvp_reg[15:8];
			vic_pkg::ADDR_FVL:  rdata_next = fvp_reg[7:0];
			vic_pkg::ADDR_REQ:  rdata_next = status_reg;
			vic_pkg::ADDR_MASK: rdata_next = mask_reg;
			vic_pkg::ADDR_SYM:  rdata_next = {3'h0, sym_reg};
			vic_pkg::ADDR_PRIO: rdata_next = prio_reg;
			default:            rdata_next = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			sym_reg    <= vic_pkg::RST_SYM[4:0];
			mask_reg   <= vic_pkg::RST_MASK;
			prio_reg   <= vic_pkg::RST_PRIO;
			fvp_reg    <= {vic_pkg::RST_FV, vic_pkg::RST_FV};
			status_reg <= vic_pkg::RST_REQ;
			pend_reg   <= vic_pkg::RST_REQ;
			rdata_reg  <= 8'h00;
			pulse_reg  <= 8'h00;
		end
		else
		begin
			sym_reg    <= sym_next;
			mask_reg   <= mask_next;
			prio_reg   <= prio_next;
			fvp_reg    <= fvp_next;
			status_reg <= status_next;
			pend_reg   <= pend_next;
			rdata_reg  <= rdata_next;
			pulse_reg  <= pulse_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Entry and return machine; padding holds entry to its cycle budget
	always_comb
	begin
		st_next     = st_reg;
		ctl_next    = ctl_reg;
		ctl_next.push       = 1'b0;
		ctl_next.rom_rd     = 1'b0;
		ctl_next.pc_load    = 1'b0;
		ctl_next.flags_load = 1'b0;
		cnt_next    = cnt_reg + 5'd1;
		total_next  = total_reg;
		lvl_next    = lvl_reg;
		pcs_next    = pcs_reg;
		flgs_next   = flgs_reg;
		vhi_next    = vhi_reg;
		shadow_next = shadow_reg;
		fast_next   = fast_reg;
		ack_next    = 1'b0;
		case (st_reg)
			vic_pkg::ST_IDLE:
			begin
				cnt_next = 5'd1;
				if (return_from_service_in)
				begin
					ctl_next.pc_load    = 1'b1;
					ctl_next.flags_load = 1'b1;
					if (fast_reg)
					begin
						ctl_next.pc    = fvp_reg;
						ctl_next.flags = shadow_reg;
						fast_next      = 1'b0;
					end
					else
					begin
						ctl_next.pc    = ret_pc_in;
						ctl_next.flags = ret_flags_in;
					end
				end
				else if (instr_end_in && sym_reg[vic_pkg::SYM_GIE] &&
					win_valid)
				begin
					ack_next  = 1'b1;
					lvl_next  = win_level;
					pcs_next  = pc_in;
					flgs_next = flags_in;
					if (sym_reg[vic_pkg::SYM_FIE] &&
						win_level == sym_reg[4:vic_pkg::SYM_FSEL])
					begin
						// Old pointer is the target; it is swapped out now
						st_next     = vic_pkg::ST_FAST;
						ctl_next.pc = fvp_reg;
						total_next  = vic_pkg::FAST_ENTRY_CYC;
						shadow_next = flags_in;
					end
					else
					begin
						st_next    = vic_pkg::ST_PCL;
						total_next = vic_pkg::NORMAL_ENTRY_CYC;
					end
				end
			end
			vic_pkg::ST_PCL:
			begin
				ctl_next.push      = 1'b1;
				ctl_next.push_data = pcs_reg[7:0];
				st_next            = vic_pkg::ST_PCH;
			end
			vic_pkg::ST_PCH:
			begin
				ctl_next.push      = 1'b1;
				ctl_next.push_data = pcs_reg[15:8];
				st_next            = vic_pkg::ST_FLG;
			end
			vic_pkg::ST_FLG:
			begin
				ctl_next.push      = 1'b1;
				ctl_next.push_data = flgs_reg;
				st_next            = vic_pkg::ST_VH;
			end
			vic_pkg::ST_VH:
			begin
				ctl_next.rom_rd   = 1'b1;
				ctl_next.rom_addr = VEC_BASE + {4'h0, lvl_reg, 1'b0};
				st_next           = vic_pkg::ST_VL;
			end
			vic_pkg::ST_VL:
			begin
				vhi_next          = rom_data_in;
				ctl_next.rom_rd   = 1'b1;
				ctl_next.rom_addr = ctl_reg.rom_addr + 8'h01;
				st_next           = vic_pkg::ST_VCAP;
			end
			vic_pkg::ST_VCAP:
			begin
				ctl_next.pc = {vhi_reg, rom_data_in};
				st_next     = vic_pkg::ST_BR;
			end
			vic_pkg::ST_FAST:
			begin
				fast_next   = 1'b1;
				st_next     = vic_pkg::ST_BR;
			end
			vic_pkg::ST_BR:
			begin
				if (cnt_reg == total_reg - 5'd1)
				begin
					ctl_next.pc_load = 1'b1;
					st_next          = vic_pkg::ST_IDLE;
				end
			end
			default:
				st_next = vic_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			st_reg     <= vic_pkg::ST_IDLE;
			ctl_reg    <= '0;
			cnt_reg    <= 5'd0;
			total_reg  <= 5'd0;
			lvl_reg    <= 3'd0;
			pcs_reg    <= 16'h0000;
			flgs_reg   <= 8'h00;
			vhi_reg    <= 8'h00;
			shadow_reg <= 8'h00;
			fast_reg   <= 1'b0;
			ack_reg    <= 1'b0;
		end
		else
		begin
			st_reg     <= st_next;
			ctl_reg    <= ctl_next;
			cnt_reg    <= cnt_next;
			total_reg  <= total_next;
			lvl_reg    <= lvl_next;
			pcs_reg    <= pcs_next;
			flgs_reg   <= flgs_next;
			vhi_reg    <= vhi_next;
			shadow_reg <= shadow_next;
			fast_reg   <= fast_next;
			ack_reg    <= ack_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	always_comb
	begin
		reg_rdata_out          = rdata_reg;
		cpu_ctl_out            = ctl_reg;
		acknowledge_strobe_out = ack_reg;
		ack_level_out          = lvl_reg;
		busy_out               = (st_reg != vic_pkg::ST_IDLE);
		fast_status_out        = fast_reg;
		level_pulse_out        = pulse_reg;
	end

endmodule

`default_nettype wire

// [rtl/vic_pkg.sv]
// Constants, state codes and carrier types of the interrupt controller.
// Assumes a single 100 MHz core clock shared with the CPU core.
`default_nettype none

package vic_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register file offsets
	localparam logic [7:0] ADDR_FVH  = 8'hda;
	localparam logic [7:0] ADDR_FVL  = 8'hdb;
	localparam logic [7:0] ADDR_REQ  = 8'hdc;
	localparam logic [7:0] ADDR_MASK = 8'hdd;
	localparam logic [7:0] ADDR_SYM  = 8'hde;
	localparam logic [7:0] ADDR_PRIO = 8'hff;

	// Reset values
	localparam logic [7:0] RST_SYM  = 8'h00;
	localparam logic [7:0] RST_REQ  = 8'h00;
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [7:0] RST_PRIO = 8'h00;
	localparam logic [7:0] RST_FV   = 8'h00;

	// Mode register fields
	localparam int SYM_GIE  = 0;
	localparam int SYM_FIE  = 1;
	localparam int SYM_FSEL = 2;
	localparam int SYM_W    = 5;

	// Priority register fields
	localparam int PRIO_A   = 0;
	localparam int PRIO_G0  = 1;
	localparam int PRIO_G1  = 4;
	localparam int PRIO_C   = 5;
	localparam int PRIO_SUB = 6;
	localparam int PRIO_G2  = 7;

	////////////////////////////////////////////////////////////////////////
	// Entry timing in clock cycles
	localparam logic [4:0] NORMAL_ENTRY_CYC = 5'h10;
	localparam logic [4:0] FAST_ENTRY_CYC   = 5'h06;

	// Levels whose pending bit is hidden and cleared by hardware
	localparam logic [7:0] HW_CLEAR_LEVELS = 8'h0f;
	localparam logic [7:0] VECTOR_BASE     = 8'h00;

	// Group order per {prio7,prio4,prio1}: {first,second,third}, A=0 B=1 C=2
	localparam logic [47:0] GROUP_ORDER_DEF = {
		6'h24, 6'h09, 6'h24, 6'h21, 6'h12, 6'h06, 6'h18, 6'h06};

	////////////////////////////////////////////////////////////////////////
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_PCL  = 4'h1,
		ST_PCH  = 4'h3,
		ST_FLG  = 4'h2,
		ST_VH   = 4'h6,
		ST_VL   = 4'h7,
		ST_VCAP = 4'h5,
		ST_BR   = 4'h4,
		ST_FAST = 4'h8
	} entry_state_t;

	typedef struct packed {
		logic        push;
		logic [7:0]  push_data;
		logic        rom_rd;
		logic [7:0]  rom_addr;
		logic        pc_load;
		logic [15:0] pc;
		logic        flags_load;
		logic [7:0]  flags;
	} cpu_ctl_t;

endpackage

`default_nettype wire

// [test/tb_vectored_interrupt_controller.sv]
// Self-checking bench of the vectored interrupt controller.
// Assumes the ROM model and the bound port checker.
`default_nettype none

module tb_vectored_interrupt_controller;
	timeunit 1ns;
	timeprecision 1ps;
	logic              ref_clk_in;
	logic              rst_n_in;
	logic [7:0]        reg_addr_in;
	logic              reg_wr_in;
	logic [7:0]        reg_wdata_in;
	logic [7:0]        reg_rdata_out;
	logic              instr_end_in;
	logic              global_unmask_instr_in;
	logic              global_mask_instr_in;
	logic              return_from_service_in;
	logic [15:0]       ret_pc_in;
	logic [7:0]        ret_flags_in;
	logic [15:0]       pc_in;
	logic [7:0]        flags_in;
	logic [7:0]        rom_data_in;
	logic [7:0]        src_req_in;
	vic_pkg::cpu_ctl_t cpu_ctl_out;
	logic              acknowledge_strobe_out;
	logic [2:0]        ack_level_out;
	logic              busy_out;
	logic              fast_status_out;
	logic [7:0]        level_pulse_out;
	int                err_count;
	int                num_checks;

	vectored_interrupt_controller u_dut (.*);
	vic_rom_model u_rom (
		.ref_clk_in   (ref_clk_in),
		.cpu_ctl_in   (cpu_ctl_out),
		.rom_data_out (rom_data_in)
	);

	////////////////////////////////////////
	task automatic finish_test;
		$display("TB: checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic ok, input string msg);
		num_checks++;
		if (!ok)
		begin
			err_count++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_in);
		reg_addr_in  <= a;
		reg_wr_in    <= 1'b1;
		reg_wdata_in <= d;
		@(posedge ref_clk_in);
		reg_wr_in <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk_in);
		reg_addr_in <= a;
		@(posedge ref_clk_in);
		@(negedge ref_clk_in);
		chk(reg_rdata_out === e, "register read");
	endtask

	// k: return, mask, unmask pulses; m: one-cycle source events
	task automatic ev(input logic [2:0] k, input logic [7:0] m);
		@(posedge ref_clk_in);
		{return_from_service_in, global_mask_instr_in,
			global_unmask_instr_in} <= k;
		src_req_in <= src_req_in | m;
		@(posedge ref_clk_in);
		{return_from_service_in, global_mask_instr_in,
			global_unmask_instr_in} <= 3'h0;
		src_req_in <= src_req_in & ~m;
	endtask

	function automatic logic [15:0] vec(input logic [2:0] l);
		return {{4'h0, l, 1'b0} ^ 8'h3c, {4'h0, l, 1'b1} ^ 8'h3c};
	endfunction

	task automatic entry(input logic [2:0] l, input logic fst,
		input logic [15:0] v);
		int n;
		logic [7:0] pq[$];
		n = 0;
		while (acknowledge_strobe_out !== 1'b1 && n < 40)
		begin
			@(negedge ref_clk_in);
			n++;
		end
		chk(ack_level_out === l, "acknowledged level");
		n = 0;
		while (cpu_ctl_out.pc_load !== 1'b1 && n < 40)
		begin
			@(negedge ref_clk_in);
			n++;
			if (cpu_ctl_out.push === 1'b1)
				pq.push_back(cpu_ctl_out.push_data);
		end
		chk(n == (fst ? 5 : 15), "entry length");
		chk(cpu_ctl_out.pc === v, "branch target");
		chk(pq.size() == (fst ? 0 : 3), "push count");
		if (!fst)
			chk(pq[0] === 8'hef && pq[1] === 8'hbe
				&& pq[2] === 8'h5a, "push order");
	endtask

	task automatic ret(input logic [15:0] p, input logic [7:0] f);
		ev(3'h4, 8'h00);
		@(negedge ref_clk_in);
		chk(cpu_ctl_out.pc === p && cpu_ctl_out.flags === f, "return");
	endtask

	// Levels 4-7 held, 0-3 pulsed; all held levels are dropped after entry
	task automatic prio(input logic [7:0] p, input logic [7:0] m,
		input logic [2:0] l);
		ev(3'h2, 8'h00);
		wr(vic_pkg::ADDR_PRIO, p);
		@(posedge ref_clk_in);
		src_req_in <= m & 8'hf0;
		ev(3'h1, m & 8'h0f);
		entry(l, 1'b0, vec(l));
		@(posedge ref_clk_in);
		src_req_in <= 8'h00;
		ret(16'h4321, 8'h77);
	endtask

	////////////////////////////////////////
	initial
	begin
		ref_clk_in = 1'b0;
		forever
			#5 ref_clk_in = ~ref_clk_in;
	end

	initial
	begin
		#100000;
		err_count++;
		finish_test();
	end

	initial
	begin
		{reg_addr_in, reg_wr_in, reg_wdata_in, instr_end_in} = '0;
		{global_unmask_instr_in, global_mask_instr_in} = 2'h0;
		{return_from_service_in, src_req_in} = '0;
		{ret_pc_in, ret_flags_in} = {16'h4321, 8'h77};
		{pc_in, flags_in} = {16'hbeef, 8'h5a};
		{err_count, num_checks} = '0;
		rst_n_in = 1'b0;
		repeat (3) @(posedge ref_clk_in);
		rst_n_in <= 1'b1;
		rd(vic_pkg::ADDR_SYM, 8'h00);
		rd(vic_pkg::ADDR_REQ, 8'h00);
		wr(vic_pkg::ADDR_REQ, 8'hff);
		rd(vic_pkg::ADDR_REQ, 8'h00);
		rd(8'h10, 8'h00);
		wr(vic_pkg::ADDR_SYM, 8'he0);
		rd(vic_pkg::ADDR_SYM, 8'h00);
		ev(3'h1, 8'h00);
		rd(vic_pkg::ADDR_SYM, 8'h01);
		ev(3'h3, 8'h00);
		rd(vic_pkg::ADDR_SYM, 8'h00);
		// Requests seen while globally disabled
		ev(3'h0, 8'h04);
		@(posedge ref_clk_in);
		src_req_in <= 8'h20;
		rd(vic_pkg::ADDR_REQ, 8'h24);
		wr(vic_pkg::ADDR_MASK, 8'hfb);
		rd(vic_pkg::ADDR_MASK, 8'hfb);
		ev(3'h1, 8'h00);
		repeat (6) @(negedge ref_clk_in);
		chk(busy_out === 1'b0, "taken outside instruction end");
		@(posedge ref_clk_in);
		instr_end_in <= 1'b1;
		entry(3'h5, 1'b0, vec(3'h5));
		rd(vic_pkg::ADDR_SYM, 8'h00);
		@(posedge ref_clk_in);
		src_req_in <= 8'h00;
		ret(16'h4321, 8'h77);
		rd(vic_pkg::ADDR_SYM, 8'h01);
		rd(vic_pkg::ADDR_REQ, 8'h04);
		wr(vic_pkg::ADDR_MASK, 8'hff);
		entry(3'h2, 1'b0, vec(3'h2));
		ret(16'h4321, 8'h77);
		rd(vic_pkg::ADDR_REQ, 8'h00);
		prio(8'h02, 8'h24, 3'h2);
		prio(8'h82, 8'h30, 3'h5);
		prio(8'h60, 8'he0, 3'h7);
		prio(8'h01, 8'h03, 3'h1);
		entry(3'h0, 1'b0, vec(3'h0));
		ret(16'h4321, 8'h77);
		// Fast level selected but fast path off
		wr(vic_pkg::ADDR_SYM, 8'h0d);
		ev(3'h0, 8'h08);
		entry(3'h3, 1'b0, vec(3'h3));
		ret(16'h4321, 8'h77);
		wr(vic_pkg::ADDR_FVH, 8'h12);
		wr(vic_pkg::ADDR_FVL, 8'h34);
		wr(vic_pkg::ADDR_SYM, 8'h0f);
		ev(3'h0, 8'h08);
		entry(3'h3, 1'b1, 16'h1234);
		chk(fast_status_out === 1'b1, "fast status");
		rd(vic_pkg::ADDR_FVH, 8'hbe);
		ret(16'hbeef, 8'h5a);
		chk(fast_status_out === 1'b0, "fast status kept");
		rd(vic_pkg::ADDR_SYM, 8'h0f);
		finish_test();
	end
endmodule

`default_nettype wire

// [test/vic_assertions.sv]
// Port checker of the vectored interrupt controller.
// Assumes it is bound to the top module; one clock domain.
`default_nettype none

module vic_assertions (
	// Clock and reset
	input wire logic              ref_clk_in,
	input wire logic              rst_n_in,
	// Watched ports
	input wire logic              return_from_service_in,
	input wire vic_pkg::cpu_ctl_t cpu_ctl_out,
	input wire logic              acknowledge_strobe_out,
	input wire logic              busy_out,
	input wire logic              fast_status_out,
	input wire logic [7:0]        level_pulse_out
);
	default clocking @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	chk_ack_single: assert property (
		acknowledge_strobe_out |=> !acknowledge_strobe_out)
		else $error("acknowledge longer than one cycle");
	chk_ack_busy: assert property (
		acknowledge_strobe_out |-> busy_out)
		else $error("acknowledge without entry");
	chk_first_push: assert property (
		acknowledge_strobe_out |=> cpu_ctl_out.push || fast_status_out)
		else $error("entry did not start with a push");
	chk_normal_time: assert property (
		acknowledge_strobe_out ##1 !fast_status_out
		|-> ##14 cpu_ctl_out.pc_load)
		else $error("normal entry length wrong");
	chk_fast_time: assert property (
		$rose(fast_status_out) |-> ##4 cpu_ctl_out.pc_load)
		else $error("fast entry length wrong");
	chk_vec_even: assert property (
		$rose(cpu_ctl_out.rom_rd) |-> !cpu_ctl_out.rom_addr[0])
		else $error("vector fetch from odd address");
	chk_vec_pair: assert property (
		$rose(cpu_ctl_out.rom_rd) |=> cpu_ctl_out.rom_rd
		&& cpu_ctl_out.rom_addr == $past(cpu_ctl_out.rom_addr) + 8'h01)
		else $error("vector low byte not fetched next");
	chk_ret_load: assert property (
		return_from_service_in && !busy_out
		|=> cpu_ctl_out.pc_load && cpu_ctl_out.flags_load)
		else $error("return did not restore state");
	chk_ret_fast: assert property (
		return_from_service_in && !busy_out |=> !fast_status_out)
		else $error("fast status kept after return");
	chk_hidden_only: assert property (
		level_pulse_out[7:4] == 4'h0)
		else $error("pulse on a software cleared level");
endmodule

bind vectored_interrupt_controller vic_assertions u_chk (
	.ref_clk_in             (ref_clk_in),
	.rst_n_in               (rst_n_in),
	.return_from_service_in (return_from_service_in),
	.cpu_ctl_out            (cpu_ctl_out),
	.acknowledge_strobe_out (acknowledge_strobe_out),
	.busy_out               (busy_out),
	.fast_status_out        (fast_status_out),
	.level_pulse_out        (level_pulse_out)
);

`default_nettype wire

// [test/vic_rom_model.sv]
// Program memory model answering vector fetches.
// Assumes fetch strobe and address arrive registered.
`default_nettype none

module vic_rom_model (
	// Clock
	input  wire logic              ref_clk_in,
	// Fetch request and answer
	input  wire vic_pkg::cpu_ctl_t cpu_ctl_in,
	output logic [7:0]             rom_data_out
);
	logic [7:0] idle_reg;
	initial idle_reg = 8'h00;
	// Idle bus toggles so stale data is never mistaken for an answer
	always @(posedge ref_clk_in)
	begin
		idle_reg <= ~idle_reg;
	end
	// Answer stands in the cycle in which the fetch strobe is high
	assign rom_data_out = cpu_ctl_in.rom_rd ?
		(cpu_ctl_in.rom_addr ^ 8'h3c) : idle_reg;
endmodule

`default_nettype wire
